/* verilog/ext_bus_pkg.sv */
// Purpose: Shared constants and carriers for the external memory bus control block
// Assumes: 50 MHz core clock, Avalon-MM register access with 32-bit data
// Notes: Address-mode codes and status layout are fixed here for every file
package ext_bus_pkg;

  // Clock and instruction cycle
  localparam int CLK_MHZ = 50;
  localparam int TCY_CLKS = 4;

  // Register byte offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;

  // Control register layout
  localparam int CTL_RELEASE_BIT = 7;
  localparam int CTL_STALL_LSB = 4;
  localparam int CTL_WMODE_LSB = 0;
  localparam logic [7:0] CONTROL_MASK = 8'hb3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Status register layout
  localparam int ST_RELEASE_BIT = 7;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_OWN_BIT = 5;
  localparam int ST_READY_BIT = 4;
  localparam int ST_STALL_EN_BIT = 3;
  localparam int ST_WIDE_BIT = 2;
  localparam int ST_MODE_LSB = 0;

  // Mode and address width codes
  localparam logic [1:0] MODE_A20 = 2'h0;
  localparam logic [1:0] MODE_A16 = 2'h1;
  localparam logic [1:0] MODE_A12 = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;

  // Wide write modes
  localparam logic [1:0] WM_SELECT = 2'h1;
  localparam logic [1:0] WM_BYTE = 2'h0;
  localparam int WM_WORD_BIT = 1;

  // Line masks
  localparam logic [19:0] MASK_A20 = 20'hfffff;
  localparam logic [19:0] MASK_A16 = 20'h0ffff;
  localparam logic [19:0] MASK_A12 = 20'h00fff;
  localparam logic [19:0] DATA_MASK_WIDE = 20'h0ffff;
  localparam logic [19:0] DATA_MASK_NARROW = 20'h000ff;

  // Fuse value held until the configuration is captured
  localparam logic [3:0] FUSE_RESET = {1'b0, 1'b1, MODE_OFF};

  typedef struct packed {
    logic stall_en;
    logic data_wide;
    logic [1:0] addr_mode;
  } fuse_t;

  typedef struct packed {
    logic start;
    logic write;
    logic [20:0] addr;
    logic [7:0] latch;
  } tbl_req_t;

  typedef struct packed {
    logic [19:0] ad_out;
    logic [19:0] ad_oe;
    logic [19:0] bus_own;
    logic ale;
    logic oe_n;
    logic ce_n;
    logic wrl_n;
    logic wrh_n;
    logic ub_n;
    logic lb_n;
    logic ba0;
  } bus_pins_t;

  localparam bus_pins_t PINS_IDLE = '{ad_out: 20'h00000, ad_oe: 20'h00000,
    bus_own: 20'h00000, ale: 1'b0, oe_n: 1'b1, ce_n: 1'b1, wrl_n: 1'b1,
    wrh_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1, ba0: 1'b0};

  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_WAIT} phase_t;

endpackage

/* verilog/sync2.sv */
// Purpose: Two-flop synchroniser for levels arriving from pins
// Assumes: Inputs are quasi-static or sampled well after settling
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2
`default_nettype wire

/* verilog/ext_mem_bus_width_control.sv */
// Purpose: External memory bus control register, width configuration and table cycles
// Assumes: Core-side inputs are on clk; fuse and bus data pins are asynchronous
// Notes: Pin drive is given as out/oe pairs; ownership marks lines taken from I/O
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Release bit set: bus owns pins only during external access, else ports.
// - Release bit clear: bus owns its pins permanently, ports disabled.
// - Stall code 11/10/01/00 adds 0/1/2/3 instruction cycles to table cycles.
// - Word mode on wide bus: both latch bytes out, high strobe on high byte.
// - Byte select: byte copied to both halves, high strobe plus one byte enable.
// - Byte write: byte copied to both halves, high or low strobe, never both.
// - Bits 6, 3, 2 read zero and ignore writes; reset clears all bits.
// - Address and data width come from fuses, fixed, not software writable.
// - Data width fuse set selects 16-bit data, cleared selects 8-bit.
// - Mode fuse selects 20, 16 or 12-bit addressing, or bus off.
// - Unused high address lines go to I/O, deaf to the release bit.
// - 16-bit addressing frees the top four address lines as plain I/O.
// - Address and data always share the same lines in time.
// - With bus off the control register ignores all writes.
// - Write mode is ignored when 8-bit data width is configured.
// - Stalls only with stall fuse set, after the executing instruction cycle.
// - Release set during external execution waits until internal execution.
module ext_mem_bus_width_control #(
  parameter int CLKS_PER_TCY = ext_bus_pkg::TCY_CLKS
) (
  // Clock, enable, reset
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  // Avalon-MM register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Fuse configuration pins
  input wire ext_bus_pkg::fuse_t fuse_config_low,
  // Core side
  input wire logic ext_exec,
  input wire ext_bus_pkg::tbl_req_t table_req,
  output logic table_busy,
  output logic [7:0] table_rdata,
  // External bus pins
  input wire logic [15:0] ad_in,
  output ext_bus_pkg::bus_pins_t bus_pins
);
  import ext_bus_pkg::*;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic release_eff;
    logic [1:0] fuse_cnt;
    logic fuse_ok;
    fuse_t fuse;
    phase_t phase;
    logic [7:0] cnt;
    tbl_req_t req;
    logic [7:0] table_latch_low;
    logic busy;
    logic [7:0] trd;
    bus_pins_t pins;
  } state_t;

  localparam state_t STATE_RESET = '{waitreq: 1'b1, rdata: 32'h00000000,
    ctrl: CONTROL_RESET, release_eff: 1'b0, fuse_cnt: 2'h0, fuse_ok: 1'b0,
    fuse: FUSE_RESET, phase: PH_IDLE, cnt: 8'h00, req: '0,
    table_latch_low: 8'h00, busy: 1'b0, trd: 8'h00, pins: PINS_IDLE};
  localparam logic [7:0] TCY8 = 8'(CLKS_PER_TCY);

  state_t s;
  state_t next_s;
  fuse_t fuse_sync;
  logic [15:0] ad_sync;

  sync2 #(.W(4)) u_fuse_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d(fuse_config_low),
    .q(fuse_sync)
  );

  sync2 #(.W(16)) u_ad_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d(ad_in),
    .q(ad_sync)
  );

  // Lines that belong to the bus for a given mode
  function automatic logic [19:0] line_mask(input logic [1:0] mode);
    case (mode)
      MODE_A20: line_mask = MASK_A20;
      MODE_A16: line_mask = MASK_A16;
      MODE_A12: line_mask = MASK_A12;
      default: line_mask = 20'h00000;
    endcase
  endfunction

  function automatic logic bus_on(input fuse_t f);
    bus_on = (f.addr_mode != MODE_OFF);
  endfunction

  // Stall clocks from the stall code
  function automatic logic [7:0] stall_clks(input fuse_t f, input logic [7:0] c);
    logic [7:0] tcys;
    tcys = {6'h00, ~c[CTL_STALL_LSB+:2]};
    stall_clks = f.stall_en ? 8'(tcys * TCY8) : 8'h00;
  endfunction

  always_comb begin
    logic [1:0] wm;
    logic [19:0] aword;
    logic [19:0] dword;
    logic [19:0] dmask;
    logic [19:0] own;
    logic [7:0] ctl_w;
    logic [7:0] stall;
    logic finish;
    logic live;
    wm = 2'h0;
    aword = 20'h00000;
    dword = 20'h00000;
    dmask = 20'h00000;
    own = 20'h00000;
    ctl_w = 8'h00;
    stall = 8'h00;
    finish = 1'b0;
    live = 1'b0;
    next_s = s;

    // Fuses captured once after reset release, then frozen
    if (!s.fuse_ok) begin
      if (s.fuse_cnt == 2'h3) begin
        next_s.fuse = fuse_sync;
        next_s.fuse_ok = 1'b1;
      end else begin
        next_s.fuse_cnt = s.fuse_cnt + 2'h1;
      end
    end

    // Register slave: one wait cycle then answer
    next_s.waitreq = 1'b1;
    if ((read || write) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = 32'h00000000;
      if (read && address == OFS_CONTROL) begin
        next_s.rdata[7:0] = s.ctrl & CONTROL_MASK;
      end else if (read && address == OFS_STATUS) begin
        next_s.rdata[ST_RELEASE_BIT] = s.release_eff;
        next_s.rdata[ST_BUSY_BIT] = s.busy;
        next_s.rdata[ST_OWN_BIT] = |s.pins.bus_own;
        next_s.rdata[ST_READY_BIT] = s.fuse_ok;
        next_s.rdata[ST_STALL_EN_BIT] = s.fuse.stall_en;
        next_s.rdata[ST_WIDE_BIT] = s.fuse.data_wide;
        next_s.rdata[ST_MODE_LSB+:2] = s.fuse.addr_mode;
      end
    end
    ctl_w = writedata[7:0] & CONTROL_MASK;
    if (write && !s.waitreq && address == OFS_CONTROL && byteenable[0]
        && s.fuse_ok && bus_on(s.fuse)) begin
      next_s.ctrl = ctl_w;
    end

    // Release takes effect only outside external execution
    if (!next_s.ctrl[CTL_RELEASE_BIT]) begin
      next_s.release_eff = 1'b0;
    end else if (!ext_exec) begin
      next_s.release_eff = 1'b1;
    end

    // Table cycle sequencer
    wm = s.ctrl[CTL_WMODE_LSB+:2];
    stall = stall_clks(s.fuse, s.ctrl);
    case (s.phase)
      PH_IDLE: begin
        if (table_req.start && s.fuse_ok && bus_on(s.fuse)) begin
          if (table_req.write && s.fuse.data_wide && wm[WM_WORD_BIT]
              && !table_req.addr[0]) begin
            next_s.table_latch_low = table_req.latch;
          end else begin
            next_s.phase = PH_ADDR;
            next_s.req = table_req;
            next_s.busy = 1'b1;
          end
        end
      end
      PH_ADDR: begin
        next_s.phase = PH_DATA;
        next_s.cnt = TCY8 - 8'h01;
      end
      PH_DATA: begin
        if (s.cnt != 8'h00) begin
          next_s.cnt = s.cnt - 8'h01;
        end else if (stall != 8'h00) begin
          next_s.phase = PH_WAIT;
          next_s.cnt = stall - 8'h01;
        end else begin
          finish = 1'b1;
        end
      end
      PH_WAIT: begin
        if (s.cnt != 8'h00) begin
          next_s.cnt = s.cnt - 8'h01;
        end else begin
          finish = 1'b1;
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase
    if (finish) begin
      next_s.phase = PH_IDLE;
      next_s.busy = 1'b0;
      if (!s.req.write) begin
        if (s.fuse.data_wide && s.req.addr[0]) begin
          next_s.trd = ad_sync[15:8];
        end else begin
          next_s.trd = ad_sync[7:0];
        end
      end
    end

    // Pin ownership and drive
    own = line_mask(next_s.fuse.addr_mode);
    live = bus_on(next_s.fuse) && (!next_s.release_eff || ext_exec
      || next_s.phase != PH_IDLE);
    next_s.pins = PINS_IDLE;
    next_s.pins.bus_own = live ? own : 20'h00000;
    aword = next_s.fuse.data_wide ? next_s.req.addr[20:1] : next_s.req.addr[19:0];
    dmask = next_s.fuse.data_wide ? DATA_MASK_WIDE : DATA_MASK_NARROW;
    if (next_s.fuse.data_wide && wm[WM_WORD_BIT]) begin
      dword = {4'h0, next_s.req.latch, next_s.table_latch_low};
    end else begin
      dword = {4'h0, next_s.req.latch, next_s.req.latch};
    end
    if (live && next_s.phase != PH_IDLE) begin
      next_s.pins.ce_n = 1'b0;
      next_s.pins.ba0 = next_s.req.addr[0];
      if (next_s.phase == PH_ADDR) begin
        next_s.pins.ale = 1'b1;
        next_s.pins.ad_out = aword & own;
        next_s.pins.ad_oe = own;
      end else begin
        next_s.pins.ad_out = ((aword & ~dmask) | (dword & dmask)) & own;
        if (next_s.req.write) begin
          next_s.pins.ad_oe = own;
          if (!next_s.fuse.data_wide) begin
            next_s.pins.wrl_n = 1'b0;
          end else if (wm[WM_WORD_BIT]) begin
            next_s.pins.wrh_n = 1'b0;
            next_s.pins.ub_n = 1'b0;
            next_s.pins.lb_n = 1'b0;
          end else if (wm == WM_SELECT) begin
            next_s.pins.wrh_n = 1'b0;
            next_s.pins.ub_n = !next_s.req.addr[0];
            next_s.pins.lb_n = next_s.req.addr[0];
          end else begin
            next_s.pins.wrh_n = !next_s.req.addr[0];
            next_s.pins.wrl_n = next_s.req.addr[0];
          end
        end else begin
          next_s.pins.ad_oe = own & ~dmask;
          next_s.pins.oe_n = 1'b0;
          next_s.pins.ub_n = 1'b0;
          next_s.pins.lb_n = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= STATE_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign readdata = s.rdata;
  assign waitrequest = s.waitreq;
  assign table_busy = s.busy;
  assign table_rdata = s.trd;
  assign bus_pins = s.pins;

  // Checks
  sequence seq_addr_phase;
    s.phase == PH_ADDR && s.pins.ale;
  endsequence

  sequence seq_data_phase;
    s.phase == PH_DATA && !s.pins.ale && !s.pins.ce_n;
  endsequence

  a_unimpl_bits_zero: assert property (@(posedge clk) disable iff (!nrst)
    (s.ctrl & ~CONTROL_MASK) == 8'h00)
    else $error("Unimplemented control bits not zero");

  a_release_to_io: assert property (@(posedge clk) disable iff (!nrst)
    ce && next_s.release_eff && !ext_exec && next_s.phase == PH_IDLE
    |=> s.pins.bus_own == 20'h00000)
    else $error("Released bus still owns pins");

  a_bus_always_on: assert property (@(posedge clk) disable iff (!nrst)
    ce && !next_s.release_eff && next_s.fuse_ok && bus_on(next_s.fuse)
    |=> s.pins.bus_own == line_mask(s.fuse.addr_mode))
    else $error("Enabled bus lost pins");

  a_stall_load: assert property (@(posedge clk) disable iff (!nrst)
    ce && s.phase == PH_DATA && s.cnt == 8'h00 && stall_clks(s.fuse, s.ctrl) != 8'h00
    |=> s.phase == PH_WAIT && s.cnt == stall_clks(s.fuse, s.ctrl) - 8'h01)
    else $error("Wrong stall length");

  a_word_strobe: assert property (@(posedge clk) disable iff (!nrst)
    !s.pins.wrh_n && s.fuse.data_wide && s.ctrl[WM_WORD_BIT]
    |-> s.pins.ad_out[15:0] == {s.req.latch, s.table_latch_low} && s.pins.wrl_n)
    else $error("Word write data or strobe wrong");

  a_select_enable: assert property (@(posedge clk) disable iff (!nrst)
    !s.pins.wrh_n && s.fuse.data_wide && s.ctrl[1:0] == WM_SELECT
    |-> (s.pins.ub_n ^ s.pins.lb_n) && s.pins.ad_out[15:8] == s.pins.ad_out[7:0])
    else $error("Byte select enables wrong");

  a_one_strobe: assert property (@(posedge clk) disable iff (!nrst)
    s.fuse.data_wide && s.ctrl[1:0] == WM_BYTE && s.req.write && s.phase == PH_DATA
    |-> (s.pins.wrh_n ^ s.pins.wrl_n))
    else $error("Byte write strobes not exclusive");

  a_fuse_frozen: assert property (@(posedge clk) disable iff (!nrst)
    s.fuse_ok |=> s.fuse_ok && $stable(s.fuse))
    else $error("Fuse configuration changed");

  a_narrow_lines: assert property (@(posedge clk) disable iff (!nrst)
    s.fuse.addr_mode == MODE_A16 |-> s.pins.bus_own[19:16] == 4'h0
      && s.pins.ad_oe[19:16] == 4'h0)
    else $error("Freed address lines driven");

  a_mux_order: assert property (@(posedge clk) disable iff (!nrst)
    (seq_addr_phase and ce) |=> seq_data_phase)
    else $error("Data phase did not follow address phase");

  a_off_no_write: assert property (@(posedge clk) disable iff (!nrst)
    s.fuse_ok && s.fuse.addr_mode == MODE_OFF |-> s.ctrl == CONTROL_RESET)
    else $error("Control written while bus off");

  a_narrow_strobe: assert property (@(posedge clk) disable iff (!nrst)
    !s.fuse.data_wide |-> s.pins.wrh_n && s.pins.ub_n && s.pins.lb_n || !s.pins.oe_n)
    else $error("Wide strobes on narrow bus");

  a_defer_release: assert property (@(posedge clk) disable iff (!nrst)
    ce && ext_exec && !s.release_eff |=> !s.release_eff)
    else $error("Release took effect during external execution");

endmodule // ext_mem_bus_width_control
`default_nettype wire

/* testbench/ext_mem_model.sv */
// Purpose: Behavioural parallel memory on the multiplexed address/data bus
// Assumes: Read word is derived from the latched address
// Notes: When not driving, its data lines toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // Clock
  input wire logic clk,
  // Bus pins
  input wire ext_bus_pkg::bus_pins_t pins,
  output logic [15:0] ad_in
);
  import ext_bus_pkg::*;
  logic [19:0] la = 20'h00000;
  logic [15:0] wd = 16'h0000;
  logic [3:0] st = 4'h0;
  logic ba = 1'b0;
  logic [15:0] idle = 16'h0000;
  always @(posedge clk) begin
    idle <= ~idle;
    if (pins.ale) begin
      la <= pins.ad_out;
      ba <= pins.ba0;
      st <= 4'h0;
    end else if (!pins.wrl_n || !pins.wrh_n) begin
      wd <= pins.ad_out[15:0];
      st <= {~pins.wrl_n, ~pins.wrh_n, ~pins.ub_n, ~pins.lb_n};
    end
  end
  assign ad_in = (!pins.oe_n && !pins.ce_n) ? {la[7:0] ^ 8'h5a, la[7:0]} : idle;
endmodule // ext_mem_model
`default_nettype wire

/* testbench/ext_mem_bus_width_control_test.sv */
// Purpose: Self-checking bench for the external bus control block
// Assumes: Avalon accesses and table cycles driven on rising edges
// Notes: Fuses are captured once per reset, so each setup reboots
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module ext_mem_bus_width_control_test;
  import ext_bus_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  fuse_t fuse = '0;
  logic ext_exec = 1'b0;
  tbl_req_t treq = '0;
  logic table_busy;
  logic [7:0] table_rdata;
  logic [15:0] ad_in;
  bus_pins_t pins;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  int n;
  initial begin
    forever #10 clk = ~clk;
  end
  ext_mem_bus_width_control #(.CLKS_PER_TCY(4)) DUT (.clk(clk), .ce(1'b1), .nrst(nrst),
    .address(address), .read(read), .write(write), .byteenable(4'hf),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .fuse_config_low(fuse), .ext_exec(ext_exec), .table_req(treq),
    .table_busy(table_busy), .table_rdata(table_rdata), .ad_in(ad_in), .bus_pins(pins));
  ext_mem_model mem (.clk(clk), .pins(pins), .ad_in(ad_in));
  task automatic wrap_up();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic timed_out();
    err_total++;
    $display("wrong value wait bound exp 1 got 0");
    wrap_up();
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) timed_out();
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic tbl(input logic wr, input logic [20:0] a, input logic [7:0] lt);
    int i;
    @(posedge clk);
    treq <= '{start: 1'b1, write: wr, addr: a, latch: lt};
    @(posedge clk);
    treq.start <= 1'b0;
    n = 0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (table_busy === 1'b1) n++;
      else if (n > 0 || i > 3) break;
    end
    if (i == 60) timed_out();
  endtask
  task automatic boot(input fuse_t f);
    nrst <= 1'b0;
    fuse <= f;
    repeat (10) @(posedge clk);
    `CHK("reset pins", PINS_IDLE, pins)
    `CHK("reset wait", 1'b1, waitrequest)
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic own(input logic [19:0] e);
    repeat (3) @(posedge clk);
    `CHK("bus_own", e, pins.bus_own)
  endtask
  task automatic status(input logic [31:0] e);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", e, rd)
  endtask
  initial begin
    boot('{stall_en: 1'b1, data_wide: 1'b1, addr_mode: MODE_A20});
    status(32'h3c);
    bus(1'b0, OFS_CONTROL, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    bus(1'b1, OFS_CONTROL, 32'hff);
    bus(1'b0, OFS_CONTROL, 32'h0);
    `CHK("ctrl mask", 32'hb3, rd)
    bus(1'b0, 4'h8, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, OFS_CONTROL, 32'h00);
    own(20'hfffff);
    bus(1'b1, OFS_CONTROL, 32'h80);
    own(20'h00000);
    ext_exec <= 1'b1;
    own(20'hfffff);
    bus(1'b1, OFS_CONTROL, 32'h00);
    bus(1'b1, OFS_CONTROL, 32'h80);
    status(32'h3c);
    own(20'hfffff);
    ext_exec <= 1'b0;
    own(20'h00000);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFS_CONTROL, 32'(c) << 4);
      tbl(1'b0, 21'h012345 + 21'(c << 1), 8'h00);
      `CHK("stall", 5 + (3 - c) * 4, n)
      `CHK("ale addr", 20'h091a2 + 20'(c), mem.la)
      `CHK("ba0", 1'b1, mem.ba)
      `CHK("rdata", 8'(8'ha2 + 8'(c)) ^ 8'h5a, table_rdata)
    end
    bus(1'b1, OFS_CONTROL, 32'h30);
    tbl(1'b1, 21'h000101, 8'h3c);
    `CHK("bw data", 16'h3c3c, mem.wd)
    `CHK("bw odd", 2'b01, mem.st[3:2])
    tbl(1'b1, 21'h000100, 8'h3c);
    `CHK("bw even", 2'b10, mem.st[3:2])
    bus(1'b1, OFS_CONTROL, 32'h31);
    tbl(1'b1, 21'h000101, 8'h3c);
    `CHK("bs data", 16'h3c3c, mem.wd)
    `CHK("bs strobes", 3'b110, mem.st[2:0])
    bus(1'b1, OFS_CONTROL, 32'h32);
    tbl(1'b1, 21'h000200, 8'h11);
    `CHK("ww even", 0, n)
    tbl(1'b1, 21'h000201, 8'h22);
    `CHK("ww data", 16'h2211, mem.wd)
    `CHK("ww strobes", 2'b01, mem.st[3:2])
    boot('{stall_en: 1'b0, data_wide: 1'b0, addr_mode: MODE_A16});
    status(32'h31);
    own(20'h0ffff);
    bus(1'b1, OFS_CONTROL, 32'h82);
    own(20'h00000);
    ext_exec <= 1'b1;
    own(20'h0ffff);
    ext_exec <= 1'b0;
    tbl(1'b1, 21'h000a40, 8'h5e);
    `CHK("no stall", 5, n)
    `CHK("narrow addr", 20'h00a40, mem.la)
    `CHK("narrow strobe", 2'b10, mem.st[3:2])
    `CHK("narrow data", 8'h5e, mem.wd[7:0])
    boot('{stall_en: 1'b0, data_wide: 1'b0, addr_mode: MODE_A12});
    status(32'h32);
    own(20'h00fff);
    boot('{stall_en: 1'b0, data_wide: 1'b1, addr_mode: MODE_OFF});
    status(32'h17);
    bus(1'b1, OFS_CONTROL, 32'hb3);
    bus(1'b0, OFS_CONTROL, 32'h0);
    `CHK("off ctrl", 32'h0, rd)
    own(20'h00000);
    tbl(1'b0, 21'h000010, 8'h00);
    `CHK("off table", 0, n)
    fuse <= '{stall_en: 1'b1, data_wide: 1'b0, addr_mode: MODE_A20};
    repeat (5) @(posedge clk);
    bus(1'b1, OFS_STATUS, 32'hff);
    status(32'h17);
    wrap_up();
  end
endmodule // ext_mem_bus_width_control_test
`default_nettype wire
